/* rtl/gpm_pin_output_mux.sv */
// Output control and source mux for general-purpose pin 3, AXI4-Lite slave
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module gpm_pin_output_mux #(
  parameter int RX_PORTS = 4,
  parameter int TX_PORTS = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire gpm_pkg::gpm_rx_status_t [RX_PORTS-1:0] rx_status,
  input wire logic [RX_PORTS-1:0] rx_port_enable,
  input wire gpm_pkg::gpm_tx_status_t [TX_PORTS-1:0] tx_status,
  input wire logic device_frame_valid,
  input wire logic pin0_local_value,
  output logic pin3_out,
  output logic pin3_oe_n
);
  import gpm_pkg::*;

  logic [7:0] pin3_output_control;
  logic pin3_local_mode;
  logic [31:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic wr_fire;
  logic next_pin3_out;
  logic pin3_drive_enable;
  logic pin3_local_value;
  logic [2:0] pin3_source_select;
  logic [2:0] pin3_signal_select;

  assign pin3_drive_enable = pin3_output_control[GPM_EN_BIT];
  assign pin3_local_value = pin3_output_control[GPM_VAL_BIT];
  assign pin3_source_select = pin3_output_control[GPM_SRC_LSB +: 3];
  assign pin3_signal_select = pin3_output_control[GPM_SEL_LSB +: 3];
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // Signal chosen for the pin from source and select codes
  function automatic logic pick(input logic [2:0] src, input logic [2:0] sel,
                                input gpm_rx_status_t [RX_PORTS-1:0] rx,
                                input logic [RX_PORTS-1:0] rx_en,
                                input gpm_tx_status_t [TX_PORTS-1:0] tx,
                                input logic dev_fv, input logic p0_val);
    gpm_rx_status_t r;
    gpm_tx_status_t t;
    logic any_lock;
    logic all_pass;
    logic sel_and;
    logic sel_or;
    r = rx[src[1:0]];
    t = tx[src[0]];
    any_lock = 1'b0;
    all_pass = 1'b1;
    sel_and = 1'b1;
    sel_or = 1'b0;
    for (int i = 0; i < RX_PORTS; i++) begin
      if (rx_en[i]) begin
        any_lock = any_lock | rx[i].lock;
        all_pass = all_pass & rx[i].pass;
      end
      if (t.rx_selected[i]) begin
        sel_and = sel_and & rx[i].pass;
        sel_or = sel_or | rx[i].pass;
      end
    end
    pick = 1'b0;
    if (!src[2]) begin
      // Receive port source
      case (sel)
        3'h0, 3'h1, 3'h2, 3'h3: pick = r.remote_pin[sel[1:0]];
        3'h4: pick = r.lock;
        3'h5: pick = r.pass;
        3'h6: pick = r.frame_valid;
        3'h7: pick = r.line_valid;
        default: pick = 1'b0;
      endcase
    end else if (src == GPM_SRC_STATUS) begin
      // Device status source
      case (sel)
        3'h0: pick = p0_val;
        3'h1: pick = any_lock;
        3'h2, 3'h3: pick = all_pass;
        3'h4: pick = dev_fv;
        default: pick = 1'b0;
      endcase
    end else if (src != GPM_SRC_RSVD) begin
      // Transmit port source
      case (sel)
        3'h0: pick = sel_and;
        3'h1: pick = sel_or;
        3'h2: pick = t.frame_valid;
        3'h3: pick = t.line_valid;
        3'h4: pick = t.synchronized;
        default: pick = 1'b0;
      endcase
    end
    // Reserved source 101 falls through as low; software must avoid it
    return pick;
  endfunction

  // Local mode overrides the mux so software can bit-bang the pin
  always_comb begin
    if (pin3_local_mode) begin
      next_pin3_out = pin3_local_value;
    end else begin
      next_pin3_out = pick(pin3_source_select, pin3_signal_select, rx_status, rx_port_enable,
                           tx_status, device_frame_valid, pin0_local_value);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, registered so the pin never glitches through the mux
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin3_out <= 1'b0;
      pin3_oe_n <= 1'b1;
    end else begin
      pin3_out <= next_pin3_out;
      pin3_oe_n <= !pin3_drive_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write address channel: one outstanding write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel, taken independently of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Register update; only byte lane 0 carries the 8-bit control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin3_output_control <= GPM_CTRL_RESET;
      pin3_local_mode <= GPM_AUX_RESET;
    end else if (wr_fire && w_strb[0]) begin
      if (aw_addr == GPM_CTRL_ADDR) begin
        pin3_output_control <= w_data[7:0];
      end
      if (aw_addr == GPM_AUX_ADDR) begin
        pin3_local_mode <= w_data[0];
      end
    end
  end

  // Write response follows both halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= GPM_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr == GPM_CTRL_ADDR || aw_addr == GPM_AUX_ADDR) ? GPM_RESP_OKAY : GPM_RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= GPM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= GPM_RESP_OKAY;
      if (s_axi_araddr == GPM_CTRL_ADDR) begin
        s_axi_rdata <= {24'h0, pin3_output_control};
      end else if (s_axi_araddr == GPM_AUX_ADDR) begin
        s_axi_rdata <= {31'h0, pin3_local_mode};
      end else if (s_axi_araddr == GPM_STAT_ADDR) begin
        s_axi_rdata <= {30'h0, !pin3_oe_n, pin3_out}; // Live pin state
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= GPM_RESP_DECERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the driven pin and register
  // The pin is registered, so each check but AST_RESET_ZERO looks one cycle after its cause
  AST_DRIVE_EN: assert property (@(posedge aclk) disable iff (!aresetn)
    pin3_oe_n == !$past(pin3_drive_enable)) else $error("pin enable does not follow bit 0");
  AST_LOCAL_VAL: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(pin3_local_mode) |-> pin3_out == $past(pin3_local_value)) else $error("local value not on pin");
  AST_RX_REMOTE: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pin3_local_mode && !pin3_source_select[2] && !pin3_signal_select[2])
    |=> pin3_out == $past(rx_status[pin3_source_select[1:0]].remote_pin[pin3_signal_select[1:0]]))
    else $error("remote pin value not routed");
  AST_RX_LOCK: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pin3_local_mode && !pin3_source_select[2] && pin3_signal_select == 3'h4)
    |=> pin3_out == $past(rx_status[pin3_source_select[1:0]].lock)) else $error("lock not routed");
  AST_RX_PASS: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pin3_local_mode && !pin3_source_select[2] && pin3_signal_select == 3'h5)
    |=> pin3_out == $past(rx_status[pin3_source_select[1:0]].pass)) else $error("pass not routed");
  AST_STAT_P0: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pin3_local_mode && pin3_source_select == GPM_SRC_STATUS && pin3_signal_select == 3'h0)
    |=> pin3_out == $past(pin0_local_value)) else $error("pin 0 value not routed");
  AST_STAT_LOCK: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pin3_local_mode && pin3_source_select == GPM_SRC_STATUS && pin3_signal_select == 3'h1)
    |=> pin3_out == $past(|(rx_port_enable & {rx_status[3].lock, rx_status[2].lock,
                                              rx_status[1].lock, rx_status[0].lock})))
    else $error("lock OR wrong");
  AST_STAT_PASS: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pin3_local_mode && pin3_source_select == GPM_SRC_STATUS && pin3_signal_select[2:1] == 2'h1)
    |=> pin3_out == $past(&(~rx_port_enable | {rx_status[3].pass, rx_status[2].pass,
                                               rx_status[1].pass, rx_status[0].pass})))
    else $error("pass AND wrong");
  AST_STAT_FV: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pin3_local_mode && pin3_source_select == GPM_SRC_STATUS && pin3_signal_select == 3'h4)
    |=> pin3_out == $past(device_frame_valid)) else $error("device frame valid not routed");
  AST_TX_PASS_AND: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pin3_local_mode && pin3_source_select[2:1] == 2'h3 && pin3_signal_select == 3'h0)
    |=> pin3_out == $past(&(~tx_status[pin3_source_select[0]].rx_selected | {rx_status[3].pass,
        rx_status[2].pass, rx_status[1].pass, rx_status[0].pass}))) else $error("tx pass AND wrong");
  AST_TX_PASS_OR: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pin3_local_mode && pin3_source_select[2:1] == 2'h3 && pin3_signal_select == 3'h1)
    |=> pin3_out == $past(|(tx_status[pin3_source_select[0]].rx_selected & {rx_status[3].pass,
        rx_status[2].pass, rx_status[1].pass, rx_status[0].pass}))) else $error("tx pass OR wrong");
  AST_TX_FRAME: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pin3_local_mode && pin3_source_select[2:1] == 2'h3 && pin3_signal_select == 3'h2)
    |=> pin3_out == $past(tx_status[pin3_source_select[0]].frame_valid)) else $error("tx frame not routed");
  AST_TX_LINE: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pin3_local_mode && pin3_source_select[2:1] == 2'h3 && pin3_signal_select == 3'h3)
    |=> pin3_out == $past(tx_status[pin3_source_select[0]].line_valid)) else $error("tx line not routed");
  AST_TX_SYNC: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pin3_local_mode && pin3_source_select[2:1] == 2'h3 && pin3_signal_select == 3'h4)
    |=> pin3_out == $past(tx_status[pin3_source_select[0]].synchronized)) else $error("sync not routed");
  AST_UNDEF_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pin3_local_mode && pin3_source_select[2]
     && (pin3_signal_select > 3'h4 || pin3_source_select == GPM_SRC_RSVD))
    |=> !pin3_out) else $error("undefined code not low");
  AST_CTRL_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && w_strb[0] && aw_addr == GPM_CTRL_ADDR) |=> pin3_output_control == $past(w_data[7:0])
    && s_axi_bvalid) else $error("control write lost");
  AST_RESET_ZERO: assert property (@(posedge aclk)
    $rose(aresetn) |-> pin3_output_control == GPM_CTRL_RESET && pin3_oe_n)
    else $error("control not zero after reset");
endmodule
`default_nettype wire

/* rtl/gpm_pkg.sv */
// Package: register map, field layout and carriers for the pin output mux
package gpm_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] GPM_CTRL_INDEX = 8'h13;
  localparam logic [7:0] GPM_AUX_INDEX = 8'h20;
  localparam logic [7:0] GPM_STAT_INDEX = 8'h21;
  localparam logic [31:0] GPM_CTRL_ADDR = {22'h0, GPM_CTRL_INDEX, 2'h0};
  localparam logic [31:0] GPM_AUX_ADDR = {22'h0, GPM_AUX_INDEX, 2'h0};
  localparam logic [31:0] GPM_STAT_ADDR = {22'h0, GPM_STAT_INDEX, 2'h0};
  // Control field positions
  localparam int GPM_EN_BIT = 0;
  localparam int GPM_VAL_BIT = 1;
  localparam int GPM_SRC_LSB = 2;
  localparam int GPM_SEL_LSB = 5;
  localparam logic [7:0] GPM_CTRL_RESET = 8'h00;
  localparam logic [0:0] GPM_AUX_RESET = 1'h0;
  // Source codes
  localparam logic [2:0] GPM_SRC_STATUS = 3'h4;
  localparam logic [2:0] GPM_SRC_RSVD = 3'h5;
  // AXI responses
  localparam logic [1:0] GPM_RESP_OKAY = 2'h0;
  localparam logic [1:0] GPM_RESP_DECERR = 2'h3;

  // One receive port's indications
  typedef struct packed {
    logic lock;
    logic pass;
    logic frame_valid;
    logic line_valid;
    logic [3:0] remote_pin;
  } gpm_rx_status_t;

  // One transmit port's indications
  typedef struct packed {
    logic frame_valid;
    logic line_valid;
    logic synchronized;
    logic [3:0] rx_selected;
  } gpm_tx_status_t;
endpackage

/* tb/gpm_pin_observer.sv */
// Far-side model: logic that watches general-purpose pin 3
`timescale 1ns/1ns
`default_nettype none
module gpm_pin_observer (
  input wire logic aclk,
  input wire logic pin3_out,
  input wire logic pin3_oe_n,
  output logic pin_level
);
  logic last;
  // Remember the last driven level
  always_ff @(posedge aclk) begin
    if (!pin3_oe_n) begin
      last <= pin3_out;
    end
  end
  // No pull on the line, so a released pin shows the inverse
  assign pin_level = pin3_oe_n ? ~last : pin3_out;
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the pin 3 output mux
`timescale 1ns/1ns
`default_nettype none
module tb;
  import gpm_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic dev_fv = 0, p0_val = 0;
  logic awready, wready, bvalid, arready, rvalid, pin3_out, pin3_oe_n, pin_level;
  logic [1:0] bresp, rresp;
  gpm_rx_status_t [3:0] rx = '0;
  gpm_tx_status_t [1:0] tx = '0;
  logic [3:0] rx_en = '0;
  int n_errors = 0, compares = 0, cycles = 0;
  gpm_pin_output_mux gpm_pin_output_mux_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_status(rx), .rx_port_enable(rx_en), .tx_status(tx), .device_frame_valid(dev_fv),
    .pin0_local_value(p0_val), .pin3_out(pin3_out), .pin3_oe_n(pin3_oe_n));
  gpm_pin_observer gpm_pin_observer_i (.aclk(aclk), .pin3_out(pin3_out), .pin3_oe_n(pin3_oe_n),
    .pin_level(pin_level));
  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    forever #10 aclk = ~aclk;
  end
  // Hang guard, well above the roughly 1,400 cycles needed
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task end_sim;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Write: address and data offered together, each dropped when taken
  task axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1;
        awvalid <= 0;
      end
      if (wvalid && wready) begin
        w_ok = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 0;
    @(posedge aclk);
  endtask
  task axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
    @(posedge aclk);
  endtask
  task set_ctrl(input logic [7:0] c);
    logic [1:0] r;
    axi_wr(GPM_CTRL_ADDR, {24'h0, c}, r);
    check(r, GPM_RESP_OKAY);
    repeat (2) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Reference of the pin level from source and select
  function automatic logic exp_pin(input logic [2:0] src, input logic [2:0] sel);
    logic [3:0] lk, ps, tsel;
    for (int i = 0; i < 4; i++) begin
      lk[i] = rx[i].lock;
      ps[i] = rx[i].pass;
    end
    tsel = tx[src[0]].rx_selected;
    exp_pin = 1'b0;
    if (src < 3'h4) begin
      case (sel)
        3'h4: exp_pin = rx[src[1:0]].lock;
        3'h5: exp_pin = rx[src[1:0]].pass;
        3'h6: exp_pin = rx[src[1:0]].frame_valid;
        3'h7: exp_pin = rx[src[1:0]].line_valid;
        default: exp_pin = rx[src[1:0]].remote_pin[sel[1:0]];
      endcase
    end else if (src == GPM_SRC_STATUS) begin
      case (sel)
        3'h0: exp_pin = p0_val;
        3'h1: exp_pin = |(lk & rx_en);
        3'h2, 3'h3: exp_pin = &(ps | ~rx_en);
        3'h4: exp_pin = dev_fv;
        default: exp_pin = 1'b0;
      endcase
    end else if (src[2:1] == 2'b11) begin
      case (sel)
        3'h0: exp_pin = &(ps | ~tsel);
        3'h1: exp_pin = |(ps & tsel);
        3'h2: exp_pin = tx[src[0]].frame_valid;
        3'h3: exp_pin = tx[src[0]].line_valid;
        3'h4: exp_pin = tx[src[0]].synchronized;
        default: exp_pin = 1'b0;
      endcase
    end
  endfunction
  // Every source but reserved 5 and every select under four input patterns
  task t_mux;
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 4; i++) rx[i] <= 8'(8'h39 * (i + 1) + k * 8'h47);
      for (int j = 0; j < 2; j++) tx[j] <= 7'(8'h2b * (j + 1) + k * 8'h35);
      rx_en <= 4'(k * 5 + 3);
      dev_fv <= k[0];
      p0_val <= k[1];
      for (int s = 0; s < 8; s++) begin
        for (int m = 0; m < 8; m++) begin
          if (s != 5) begin
            set_ctrl({3'(m), 3'(s), k[0], 1'b1});
            check({pin3_oe_n, pin_level}, {1'b0, exp_pin(3'(s), 3'(m))});
          end
        end
      end
    end
  endtask
  // Register map, bad addresses, enable and local value
  task t_regs;
    logic [1:0] r;
    logic [31:0] d;
    axi_rd(GPM_CTRL_ADDR, d, r);
    check({r, d}, 34'h0);
    check(pin3_oe_n, 1'b1);
    axi_wr(GPM_CTRL_ADDR, 32'hffff_ff5d, r);
    axi_rd(GPM_CTRL_ADDR, d, r);
    check(d, 32'h5d);
    axi_wr(32'h100, 32'h1, r);
    check(r, GPM_RESP_DECERR);
    axi_rd(32'h100, d, r);
    check({r, d}, {GPM_RESP_DECERR, 32'h0});
    axi_wr(GPM_AUX_ADDR, 32'h1, r);
    set_ctrl(8'h03);
    check({pin3_oe_n, pin_level}, 2'b01);
    axi_rd(GPM_STAT_ADDR, d, r);
    check(d, 32'h3);
    set_ctrl(8'h01);
    check({pin3_oe_n, pin_level}, 2'b00);
    set_ctrl(8'h02);
    check(pin3_oe_n, 1'b1);
    axi_rd(GPM_STAT_ADDR, d, r);
    check(d[1], 1'b0);
    axi_wr(GPM_AUX_ADDR, 32'h0, r);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_mux();
    end_sim();
  end
endmodule
`default_nettype wire
